// ===== hw/psrc_top.sv
// soft reset controller: three masked reset registers on an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module psrc_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [psrc_pkg::PSRC_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // capability words, static from the device configuration
  input wire logic [31:0] capability_word_one,
  input wire logic [31:0] capability_word_two,
  input wire logic [31:0] capability_word_four,
  // unit resets, high holds the unit in reset
  output psrc_pkg::psrc_core_rst_t core_rst,
  output psrc_pkg::psrc_periph_rst_t periph_rst,
  output logic [psrc_pkg::PSRC_GPIO_PORTS-1:0] gpio_port_rst
);
  import psrc_pkg::*;

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  psrc_ahb_req_t req;
  wire logic wr_pend;
  wire logic rd_pend;
  wire logic [PSRC_ADDR_W-1:0] addr_q;

  assign req = '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsize: hsize, hsel: hsel};

  psrc_ahb_slave u_slave (
    .clock(clock),
    .rst_b(rst_b),
    .req(req),
    .hready(hready),
    .wr_pend(wr_pend),
    .rd_pend(rd_pend),
    .addr_q(addr_q)
  );

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire logic hit_core;
  wire logic hit_periph;
  wire logic hit_gpio;
  assign hit_core = addr_q == PSRC_OFS_CORE;
  assign hit_periph = addr_q == PSRC_OFS_PERIPH;
  assign hit_gpio = addr_q == PSRC_OFS_GPIO;

  wire logic [31:0] core_val;
  wire logic [31:0] periph_val;
  wire logic [31:0] gpio_val;

  psrc_mask_reg #(.IMPL(PSRC_IMPL_CORE)) u_core (
    .clock(clock),
    .rst_b(rst_b),
    .we(wr_pend && hit_core),
    .wdata(hwdata),
    .cap(capability_word_one), // RL1
    .value(core_val)
  );

  psrc_mask_reg #(.IMPL(PSRC_IMPL_PERIPH)) u_periph (
    .clock(clock),
    .rst_b(rst_b),
    .we(wr_pend && hit_periph),
    .wdata(hwdata),
    .cap(capability_word_two), // RL2
    .value(periph_val)
  );

  psrc_mask_reg #(.IMPL(PSRC_IMPL_GPIO)) u_gpio (
    .clock(clock),
    .rst_b(rst_b),
    .we(wr_pend && hit_gpio),
    .wdata(hwdata),
    .cap(capability_word_four), // RL3
    .value(gpio_val)
  );

  // ---------------------------------------------------------------
  // read data: registered in the address phase's following edge
  // ---------------------------------------------------------------
  // read mux looks at the live address so data is ready in the data phase
  wire logic rd_go;
  wire logic [31:0] rd_mux;
  assign rd_go = hsel && hready && !hwrite &&
    (htrans == PSRC_HTRANS_NONSEQ || htrans == PSRC_HTRANS_SEQ);
  // unmapped addresses and reserved bits read zero
  assign rd_mux = (haddr == PSRC_OFS_CORE) ? core_val : // RL12
    (haddr == PSRC_OFS_PERIPH) ? periph_val :
    (haddr == PSRC_OFS_GPIO) ? gpio_val : 32'h0000_0000; // RL10

  psrc_core_rst_t core_next;
  psrc_periph_rst_t periph_next;
  assign core_next = '{power_mgr: core_val[PSRC_BIT_POWER_MGR], // RL4
    watchdog: core_val[PSRC_BIT_WATCHDOG]};
  assign periph_next = '{comparator_one_reset_bit: periph_val[PSRC_BIT_COMPARATOR_ONE_RESET_BIT], // RL5
    comparator_zero_reset_bit: periph_val[PSRC_BIT_COMPARATOR_ZERO_RESET_BIT],
    gp_counter_two_reset_bit: periph_val[PSRC_BIT_GP_COUNTER_TWO_RESET_BIT], // RL6
    gp_counter_one_reset_bit: periph_val[PSRC_BIT_GP_COUNTER_ONE_RESET_BIT],
    gp_counter_zero_reset_bit: periph_val[PSRC_BIT_GP_COUNTER_ZERO_RESET_BIT],
    sync_serial_zero_reset_bit: periph_val[PSRC_BIT_SYNC_SERIAL_ZERO_RESET_BIT], // RL7
    uart_unit_one_reset_bit: periph_val[PSRC_BIT_UART_UNIT_ONE_RESET_BIT], // RL8
    uart_unit_zero_reset_bit: periph_val[PSRC_BIT_UART_UNIT_ZERO_RESET_BIT]};

  // outputs lag the register by one edge so each comes from a flop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= PSRC_HRESP_OKAY;
      core_rst <= '0; // RL11
      periph_rst <= '0;
      gpio_port_rst <= '0;
    end else begin
      hrdata <= rd_go ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= PSRC_HRESP_OKAY;
      core_rst <= core_next; // RL11
      periph_rst <= periph_next;
      gpio_port_rst <= gpio_val[PSRC_GPIO_PORTS-1:0]; // RL9
    end
  end
endmodule
`default_nettype wire

// ===== pkg/psrc_pkg.sv
// package: register map, field layout and carrier types of the soft reset block
//
// Function
// RL1: writes to the core-units reset register change only bits enabled by capability word one.
// RL2: writes to the peripherals reset register change only bits enabled by capability word two.
// RL3: writes to the gpio-ports reset register change only bits enabled by capability word four.
// RL4: core-units register bit 3 resets the watchdog and bit 6 resets the power manager.
// RL5: peripherals register bits 24 and 25 reset analog comparators zero and one.
// RL6: peripherals register bits 16, 17 and 18 reset general-purpose timers zero, one and two.
// RL7: peripherals register bit 4 resets synchronous serial port zero.
// RL8: peripherals register bits 0 and 1 reset uart units zero and one.
// RL9: gpio-ports register bits 0 to 7 reset gpio ports a to h, port h at bit 7.
// RL10: reserved bits are read-only, read as zero, and software preserves them.
// RL11: every implemented bit clears on system reset and holds its unit in reset while set.
// RL12: reads return the current value of every implemented reset control bit.
package psrc_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] PSRC_OFS_CORE = 12'h040;
  localparam logic [11:0] PSRC_OFS_PERIPH = 12'h044;
  localparam logic [11:0] PSRC_OFS_GPIO = 12'h048;
  localparam int PSRC_ADDR_W = 12;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PSRC_BIT_WATCHDOG = 3;
  localparam int PSRC_BIT_POWER_MGR = 6;
  localparam int PSRC_BIT_UART_UNIT_ZERO_RESET_BIT = 0;
  localparam int PSRC_BIT_UART_UNIT_ONE_RESET_BIT = 1;
  localparam int PSRC_BIT_SYNC_SERIAL_ZERO_RESET_BIT = 4;
  localparam int PSRC_BIT_GP_COUNTER_ZERO_RESET_BIT = 16;
  localparam int PSRC_BIT_GP_COUNTER_ONE_RESET_BIT = 17;
  localparam int PSRC_BIT_GP_COUNTER_TWO_RESET_BIT = 18;
  localparam int PSRC_BIT_COMPARATOR_ZERO_RESET_BIT = 24;
  localparam int PSRC_BIT_COMPARATOR_ONE_RESET_BIT = 25;
  localparam int PSRC_GPIO_PORTS = 8;

  // implemented (writable) bits of each register; all others reserved
  localparam logic [31:0] PSRC_IMPL_CORE = 32'h0000_0048;
  localparam logic [31:0] PSRC_IMPL_PERIPH = 32'h0307_0013;
  localparam logic [31:0] PSRC_IMPL_GPIO = 32'h0000_00FF;
  localparam logic [31:0] PSRC_RESET_VAL = 32'h0000_0000;

  // ---------------------------------------------------------------
  // ahb-lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] PSRC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PSRC_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] PSRC_HSIZE_WORD = 3'h2;
  localparam logic PSRC_HRESP_OKAY = 1'b0;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] htrans;
    logic [PSRC_ADDR_W-1:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
  } psrc_ahb_req_t;

  typedef struct packed {
    logic power_mgr;
    logic watchdog;
  } psrc_core_rst_t;

  typedef struct packed {
    logic comparator_one_reset_bit;
    logic comparator_zero_reset_bit;
    logic gp_counter_two_reset_bit;
    logic gp_counter_one_reset_bit;
    logic gp_counter_zero_reset_bit;
    logic sync_serial_zero_reset_bit;
    logic uart_unit_one_reset_bit;
    logic uart_unit_zero_reset_bit;
  } psrc_periph_rst_t;

endpackage

// ===== hw/psrc_ahb_slave.sv
// ahb-lite slave front end: captures the address phase of a transfer
`timescale 1ns/1ps
`default_nettype none
module psrc_ahb_slave (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // ahb address phase
  input wire psrc_pkg::psrc_ahb_req_t req,
  input wire logic hready,
  // captured data phase
  output logic wr_pend,
  output logic rd_pend,
  output logic [psrc_pkg::PSRC_ADDR_W-1:0] addr_q
);
  import psrc_pkg::*;

  wire logic active;
  assign active = req.hsel && hready &&
    (req.htrans == PSRC_HTRANS_NONSEQ || req.htrans == PSRC_HTRANS_SEQ);

  // zero wait states: data phase always follows the next edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_pend <= active && req.hwrite;
      rd_pend <= active && !req.hwrite;
      if (active) begin
        addr_q <= req.haddr;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/psrc_mask_reg.sv
// one reset control register whose writes are masked by a capability word
`timescale 1ns/1ps
`default_nettype none
module psrc_mask_reg #(
  parameter logic [31:0] IMPL = 32'h0000_0000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // write port
  input wire logic we,
  input wire logic [31:0] wdata,
  input wire logic [31:0] cap,
  // state
  output logic [31:0] value
);
  import psrc_pkg::*;

  logic [31:0] value_reg;
  logic [31:0] value_next;
  wire logic [31:0] wmask;

  // absent units and reserved bits keep their value
  assign wmask = cap & IMPL; // RL1 RL2 RL3
  assign value_next = we ? ((value_reg & ~wmask) | (wdata & wmask)) : value_reg;
  assign value = value_reg & IMPL; // RL10

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      value_reg <= PSRC_RESET_VAL; // RL11
    end else begin
      value_reg <= value_next;
    end
  end
endmodule
`default_nettype wire

// ===== tb/psrc_assertions.sv
// checker: port-level properties of the soft reset block
`timescale 1ns/1ps
`default_nettype none
module psrc_assertions (
  // bus
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [psrc_pkg::PSRC_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // capabilities and unit resets
  input wire logic [31:0] capability_word_one,
  input wire logic [31:0] capability_word_two,
  input wire logic [31:0] capability_word_four,
  input wire psrc_pkg::psrc_core_rst_t core_rst,
  input wire psrc_pkg::psrc_periph_rst_t periph_rst,
  input wire logic [psrc_pkg::PSRC_GPIO_PORTS-1:0] gpio_port_rst
);
  import psrc_pkg::*;
  logic wr_q;
  logic rd_q;
  logic [11:0] a_q;
  // ---------------------------------------------------------------
  // register images rebuilt from the unit reset outputs
  // ---------------------------------------------------------------
  wire [31:0] core_v = {25'h0, core_rst.power_mgr, 2'h0, core_rst.watchdog, 3'h0};
  wire [31:0] peri_v = {6'h0, periph_rst.comparator_one_reset_bit, periph_rst.comparator_zero_reset_bit, 5'h0, periph_rst.gp_counter_two_reset_bit,
    periph_rst.gp_counter_one_reset_bit, periph_rst.gp_counter_zero_reset_bit, 11'h0, periph_rst.sync_serial_zero_reset_bit, 2'h0, periph_rst.uart_unit_one_reset_bit,
    periph_rst.uart_unit_zero_reset_bit};
  wire [31:0] gpio_v = {24'h0, gpio_port_rst};
  wire [31:0] core_n = (hwdata & capability_word_one & PSRC_IMPL_CORE) |
    (core_v & ~capability_word_one);
  wire [31:0] peri_n = (hwdata & capability_word_two & PSRC_IMPL_PERIPH) |
    (peri_v & ~capability_word_two);
  wire [31:0] gpio_n = (hwdata & capability_word_four & PSRC_IMPL_GPIO) |
    (gpio_v & ~capability_word_four);
  wire is_map = a_q == PSRC_OFS_CORE || a_q == PSRC_OFS_PERIPH || a_q == PSRC_OFS_GPIO;
  wire wr_map = wr_q && is_map;
  wire [31:0] rd_exp = a_q == PSRC_OFS_CORE ? core_v : a_q == PSRC_OFS_PERIPH ? peri_v :
    a_q == PSRC_OFS_GPIO ? gpio_v : 32'h0;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 12'h0;
    end else begin
      wr_q <= hsel && htrans[1] && hreadyout && hwrite;
      rd_q <= hsel && htrans[1] && hreadyout && !hwrite;
      a_q <= haddr;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // isolated write: the outputs seen now are the register that it merges into
  sequence s_wr(logic [11:0] a);
    !$past(wr_q) && wr_q && a_q == a;
  endsequence
  chk_core_mask: assert property (s_wr(PSRC_OFS_CORE) |->
    ##2 core_v == $past(core_n, 2))
    else $error("core register write mask wrong");
  chk_peri_mask: assert property (s_wr(PSRC_OFS_PERIPH) |->
    ##2 peri_v == $past(peri_n, 2))
    else $error("peripheral register write mask wrong");
  chk_gpio_mask: assert property (s_wr(PSRC_OFS_GPIO) |->
    ##2 gpio_v == $past(gpio_n, 2))
    else $error("gpio register write mask wrong");
  chk_read_back: assert property (rd_q |-> hrdata == rd_exp)
    else $error("read data differs from register");
  chk_hold_value: assert property (!$past(wr_map, 2) |->
    $stable({core_v, peri_v, gpio_v}))
    else $error("unit reset changed without write");
  chk_reset_clear: assert property ($rose(rst_b) |->
    {core_v, peri_v, gpio_v, hrdata} == '0)
    else $error("state not cleared by reset");
  chk_bus_okay: assert property (hreadyout && hresp == PSRC_HRESP_OKAY)
    else $error("bus not ready or not okay");
  chk_idle_data: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside read phase");
endmodule
bind psrc_top psrc_assertions u_chk (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hrdata, .hreadyout, .hresp, .capability_word_one, .capability_word_two,
  .capability_word_four, .core_rst, .periph_rst, .gpio_port_rst);
`default_nettype wire

// ===== tb/psrc_top_tb_top.sv
// testbench: soft reset block exercised over its register bus
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module psrc_top_tb_top;
  import psrc_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] cap1 = 32'h0;
  logic [31:0] cap2 = 32'h0;
  logic [31:0] cap4 = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hreadyout;
  logic hresp;
  psrc_core_rst_t core_rst;
  psrc_periph_rst_t periph_rst;
  logic [7:0] gpio_port_rst;
  int n_fail = 0;
  int comparisons = 0;
  always #10 clock = ~clock;
  psrc_top dut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(PSRC_HSIZE_WORD),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .capability_word_one(cap1),
    .capability_word_two(cap2), .capability_word_four(cap4), .core_rst, .periph_rst,
    .gpio_port_rst);
  // ---------------------------------------------------------------
  // bus and helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= PSRC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // unit outputs trail the register by one cycle
  task automatic settle;
    repeat (2) @(posedge clock);
  endtask
  task automatic t_zero;
    `CK({core_rst, periph_rst, gpio_port_rst}, 18'h0)
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, PSRC_OFS_CORE + 12'(4 * i), 32'h0);
      `CK(r, 32'h0)
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_core;
    cap1 <= 32'hFFFF_FFFF;
    bus(1'b1, PSRC_OFS_CORE, 32'hFFFF_FFF7);
    settle;
    `CK(core_rst, 2'b10)
    bus(1'b0, PSRC_OFS_CORE, 32'h0);
    `CK(r, 32'h40)
    cap1 <= 32'h08;
    bus(1'b1, PSRC_OFS_CORE, 32'hFFFF_FFFF);
    bus(1'b0, PSRC_OFS_CORE, 32'h0);
    `CK(r, 32'h48)
    `CK(core_rst, 2'b11)
    bus(1'b1, PSRC_OFS_CORE, 32'h0);
    settle;
    `CK(core_rst, 2'b10)
  endtask
  task automatic t_periph;
    cap2 <= 32'hFFFF_FFFF;
    bus(1'b1, PSRC_OFS_PERIPH, 32'h0205_0010);
    settle;
    `CK(periph_rst, 8'hAC)
    cap2 <= 32'h0100_0001;
    bus(1'b1, PSRC_OFS_PERIPH, 32'hFFFF_FFFF);
    bus(1'b0, PSRC_OFS_PERIPH, 32'h0);
    `CK(r, 32'h0305_0011)
    `CK(periph_rst, 8'hED)
    cap2 <= 32'h0002_0002;
    bus(1'b1, PSRC_OFS_PERIPH, 32'hFFFF_FFFF);
    settle;
    `CK(periph_rst, 8'hFF)
  endtask
  task automatic t_gpio;
    cap4 <= 32'hFF;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, PSRC_OFS_GPIO, 32'h1 << i);
      settle;
      `CK(gpio_port_rst, 8'h1 << i)
    end
    cap4 <= 32'h0F;
    bus(1'b1, PSRC_OFS_GPIO, 32'hFFFF_FFFF);
    bus(1'b0, PSRC_OFS_GPIO, 32'h0);
    `CK(r, 32'h8F)
  endtask
  task automatic t_unmapped;
    bus(1'b1, 12'h04C, 32'hFFFF_FFFF);
    bus(1'b0, 12'h04C, 32'h0);
    `CK(r, 32'h0)
    bus(1'b0, PSRC_OFS_CORE, 32'h0);
    `CK(r, 32'h40)
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
  endtask
  task final_report;
    $display("failures %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    final_report;
  end
  initial begin
    do_reset;
    t_zero;
    t_core;
    t_periph;
    t_gpio;
    t_unmapped;
    do_reset;
    t_zero;
    final_report;
  end
endmodule
`default_nettype wire
